// File: rtf_map.svh
// Constants for the tag response framer: timing, subcarrier, CRC and flag layout
`ifndef RTF_MAP_SVH
`define RTF_MAP_SVH

// ==========================================================================
// Carrier and subcarrier
// ==========================================================================
`define RTF_FC_KHZ 13560
`define RTF_DIV_LO 32
`define RTF_DIV_HI 28
`define RTF_HALF_LO 16
`define RTF_HALF_HI 14

// ==========================================================================
// Unmodulated times, in ns, and their length in lower-subcarrier periods
// ==========================================================================
`define RTF_T_GAP_LONG_NS 56640
`define RTF_T_GAP_SHORT_NS 18880
`define RTF_U_LONG ((`RTF_T_GAP_LONG_NS * `RTF_FC_KHZ / 1000000) / `RTF_DIV_LO)
`define RTF_U_SHORT ((`RTF_T_GAP_SHORT_NS * `RTF_FC_KHZ / 1000000) / `RTF_DIV_LO)
`define RTF_T_GAP_FAST_TAIL_NS 37760
`define RTF_U_FAST_TAIL ((`RTF_T_GAP_FAST_TAIL_NS * `RTF_FC_KHZ / 1000000) / `RTF_DIV_LO)

// ==========================================================================
// Pulse counts at high rate, standard commands
// ==========================================================================
`define RTF_P_LO_LONG 24
`define RTF_P_LO_SHORT 8
`define RTF_P_HI_LONG 27
`define RTF_P_HI_SHORT 9
`define RTF_LOW_SHIFT 2

// ==========================================================================
// Frame check and request flags
// ==========================================================================
`define RTF_CRC_PRESET 16'hffff
`define RTF_CRC_POLY 16'h8408
`define RTF_CRC_RESIDUE 16'hf0b8
`define RTF_FLAG_SUB 0
`define RTF_FLAG_RATE 1
`define RTF_LAST_BIT 3'h7

`endif

// File: rtf_pkg.sv
// Types shared by the tag response framer
package rtf_pkg;

	// ==================================================================
	// State machines and item kinds
	// ==================================================================
	typedef enum logic [5:0] {
		TX_IDLE = 6'h01,
		TX_SOF = 6'h02,
		TX_DATA = 6'h04,
		TX_CRC0 = 6'h08,
		TX_CRC1 = 6'h10,
		TX_EOF = 6'h20
	} rtf_tx_e;

	typedef enum logic [1:0] {
		LK_IDLE = 2'h1,
		LK_RUN = 2'h2
	} rtf_lk_e;

	typedef enum logic [1:0] {
		IT_SOF = 2'h0,
		IT_DATA = 2'h1,
		IT_EOF = 2'h2
	} rtf_item_e;

	typedef enum logic [1:0] {
		SG_UNMOD = 2'h0,
		SG_LO = 2'h1,
		SG_HI = 2'h2
	} rtf_seg_e;

	// One segment of a symbol: kind, length in periods, last of symbol
	typedef struct packed {
		logic last;
		rtf_seg_e typ;
		logic [4:0] base;
	} rtf_seg_s;

	typedef logic [7:0] rtf_byte_t;

endpackage : rtf_pkg

// File: rtf_framer.sv
// Tag response framer: request CRC check, response framing and load modulation
`timescale 1ns/10ps
`include "rtf_map.svh"

module rtf_framer #(
	parameter logic [7:0] UID_CLASS = 8'ha5, // Arbitrary value
	parameter logic [7:0] UID_MAKER = 8'h5a, // Arbitrary value
	parameter logic [47:0] UID_SERIAL = 48'h0123_4567_89ab
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic fc_clk,
	input wire logic rx_valid,
	input wire rtf_pkg::rtf_byte_t rx_byte,
	input wire logic rx_last,
	output logic rx_ok,
	output logic rx_bad,
	output logic resp_armed,
	input wire logic tx_start,
	input wire logic tx_fast,
	input wire logic tx_valid,
	input wire rtf_pkg::rtf_byte_t tx_byte,
	input wire logic tx_last,
	output logic tx_ready,
	output logic tx_busy,
	output logic tx_done,
	input wire logic afi_wr,
	input wire rtf_pkg::rtf_byte_t afi_wdata,
	input wire logic afi_lock_wr,
	output logic [3:0] afi_family,
	output logic [3:0] afi_subfamily,
	output logic afi_locked,
	output logic afi_reject,
	output logic [63:0] uid,
	output logic load_mod
);
	import rtf_pkg::*;

	// ==================================================================
	// Functions
	// ==================================================================
	// Reflected CRC-16 over one byte, LSB first
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input rtf_byte_t d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `RTF_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc_byte

	// Symbol code: 0 SOF, 1 data zero, 2 data one, 3 EOF
	function automatic logic [1:0] sym_of(input rtf_item_e k, input rtf_byte_t b,
		input logic [2:0] bi);
		if (k == IT_SOF) begin
			return 2'h0;
		end else if (k == IT_EOF) begin
			return 2'h3;
		end
		return b[bi] ? 2'h2 : 2'h1;
	endfunction : sym_of

	// Segment table of every symbol at high rate, standard command
	function automatic rtf_seg_s seg_info(input logic [1:0] sym, input logic dual,
		input logic [1:0] idx);
		rtf_seg_s s;
		s = '{1'b1, SG_UNMOD, 5'h0};
		case ({dual, sym, idx})
			5'b0_00_00: s = '{1'b0, SG_UNMOD, 5'(`RTF_U_LONG)};
			5'b0_00_01: s = '{1'b0, SG_LO, 5'(`RTF_P_LO_LONG)};
			5'b0_00_10: s = '{1'b0, SG_UNMOD, 5'(`RTF_U_SHORT)};
			5'b0_00_11: s = '{1'b1, SG_LO, 5'(`RTF_P_LO_SHORT)};
			5'b0_01_00: s = '{1'b0, SG_LO, 5'(`RTF_P_LO_SHORT)};
			5'b0_01_01: s = '{1'b1, SG_UNMOD, 5'(`RTF_U_SHORT)};
			5'b0_10_00: s = '{1'b0, SG_UNMOD, 5'(`RTF_U_SHORT)};
			5'b0_10_01: s = '{1'b1, SG_LO, 5'(`RTF_P_LO_SHORT)};
			5'b0_11_00: s = '{1'b0, SG_LO, 5'(`RTF_P_LO_SHORT)};
			5'b0_11_01: s = '{1'b0, SG_UNMOD, 5'(`RTF_U_SHORT)};
			5'b0_11_10: s = '{1'b0, SG_LO, 5'(`RTF_P_LO_LONG)};
			5'b0_11_11: s = '{1'b1, SG_UNMOD, 5'(`RTF_U_LONG)};
			5'b1_00_00: s = '{1'b0, SG_HI, 5'(`RTF_P_HI_LONG)};
			5'b1_00_01: s = '{1'b0, SG_LO, 5'(`RTF_P_LO_LONG)};
			5'b1_00_10: s = '{1'b0, SG_HI, 5'(`RTF_P_HI_SHORT)};
			5'b1_00_11: s = '{1'b1, SG_LO, 5'(`RTF_P_LO_SHORT)};
			5'b1_01_00: s = '{1'b0, SG_LO, 5'(`RTF_P_LO_SHORT)};
			5'b1_01_01: s = '{1'b1, SG_HI, 5'(`RTF_P_HI_SHORT)};
			5'b1_10_00: s = '{1'b0, SG_HI, 5'(`RTF_P_HI_SHORT)};
			5'b1_10_01: s = '{1'b1, SG_LO, 5'(`RTF_P_LO_SHORT)};
			5'b1_11_00: s = '{1'b0, SG_LO, 5'(`RTF_P_LO_SHORT)};
			5'b1_11_01: s = '{1'b0, SG_HI, 5'(`RTF_P_HI_SHORT)};
			5'b1_11_10: s = '{1'b0, SG_LO, 5'(`RTF_P_LO_LONG)};
			5'b1_11_11: s = '{1'b1, SG_HI, 5'(`RTF_P_HI_LONG)};
			default: s = '{1'b1, SG_UNMOD, 5'h0};
		endcase
		return s;
	endfunction : seg_info

	// Scale a base count: times four at low rate, halved for fast commands
	function automatic logic [8:0] units_of(input logic [4:0] base, input logic low,
		input logic fast);
		logic [8:0] b;
		b = {4'h0, base};
		if (low) begin
			b = b << `RTF_LOW_SHIFT;
		end
		if (fast) begin
			b = b >> 1;
		end
		return b;
	endfunction : units_of

	// ==================================================================
	// Identifier and family code
	// ==================================================================
	logic [63:0] uid_r;
	rtf_byte_t afi_r, afi_nxt;
	logic afi_lock_r, afi_lock_nxt, afi_rej_r, afi_rej_nxt;

	// Family code write, lock and reject
	always_comb begin
		afi_nxt = afi_r;
		afi_lock_nxt = afi_lock_r | afi_lock_wr;
		afi_rej_nxt = 1'b0;
		if (afi_wr && afi_lock_r) begin
			afi_rej_nxt = 1'b1;
		end else if (afi_wr) begin
			afi_nxt = afi_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			uid_r <= {UID_CLASS, UID_MAKER, UID_SERIAL};
			afi_r <= 8'h00;
			afi_lock_r <= 1'b0;
			afi_rej_r <= 1'b0;
		end else begin
			uid_r <= uid_r;
			afi_r <= afi_nxt;
			afi_lock_r <= afi_lock_nxt;
			afi_rej_r <= afi_rej_nxt;
		end
	end

	assign uid = uid_r;
	assign afi_family = afi_r[7:4];
	assign afi_subfamily = afi_r[3:0];
	assign afi_locked = afi_lock_r;
	assign afi_reject = afi_rej_r;

	// ==================================================================
	// Request check and response framing, clk domain
	// ==================================================================
	rtf_tx_e tx_st_r, tx_st_nxt;
	logic [15:0] rx_crc_r, rx_crc_nxt, crc_r, crc_nxt, rx_c;
	logic rx_first_r, rx_first_nxt, rx_ok_r, rx_ok_nxt, rx_bad_r, rx_bad_nxt;
	logic armed_r, armed_nxt, f_dual_r, f_dual_nxt, f_low_r, f_low_nxt;
	logic q_dual_r, q_dual_nxt, q_low_r, q_low_nxt;
	logic pend_r, pend_nxt, req_r, req_nxt, last_r, last_nxt;
	logic w_dual_r, w_dual_nxt, w_low_r, w_low_nxt, w_fast_r, w_fast_nxt;
	rtf_item_e w_kind_r, w_kind_nxt;
	rtf_byte_t w_byte_r, w_byte_nxt;
	logic tx_rdy_r, tx_rdy_nxt, tx_busy_r, tx_done_r, tx_done_nxt;
	logic ack_s1_r, ack_s2_r, ack_s3_r, ack_ev;
	logic lk_ack_r;

	// Handshake return from the link, two stages then edge detect
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_s1_r <= 1'b0;
			ack_s2_r <= 1'b0;
			ack_s3_r <= 1'b0;
		end else begin
			ack_s1_r <= lk_ack_r;
			ack_s2_r <= ack_s1_r;
			ack_s3_r <= ack_s2_r;
		end
	end

	assign ack_ev = ack_s2_r != ack_s3_r;

	// Request CRC check, response sequencing and word hand-off
	always_comb begin
		rx_crc_nxt = rx_crc_r;
		rx_first_nxt = rx_first_r;
		rx_ok_nxt = 1'b0;
		rx_bad_nxt = 1'b0;
		q_dual_nxt = q_dual_r;
		q_low_nxt = q_low_r;
		f_dual_nxt = f_dual_r;
		f_low_nxt = f_low_r;
		armed_nxt = armed_r;
		tx_st_nxt = tx_st_r;
		crc_nxt = crc_r;
		pend_nxt = pend_r;
		req_nxt = req_r;
		last_nxt = last_r;
		w_kind_nxt = w_kind_r;
		w_byte_nxt = w_byte_r;
		w_dual_nxt = w_dual_r;
		w_low_nxt = w_low_r;
		w_fast_nxt = w_fast_r;
		tx_done_nxt = 1'b0;
		rx_c = crc_byte(rx_first_r ? `RTF_CRC_PRESET : rx_crc_r, rx_byte);
		unique case (tx_st_r)
			TX_IDLE: begin
				if (tx_start && armed_r) begin
					tx_st_nxt = TX_SOF;
					crc_nxt = `RTF_CRC_PRESET;
					armed_nxt = 1'b0;
					w_fast_nxt = tx_fast;
					w_dual_nxt = f_dual_r && !tx_fast;
					w_low_nxt = f_low_r;
				end
			end
			TX_SOF, TX_CRC0, TX_CRC1, TX_EOF: begin
				if (!pend_r) begin
					pend_nxt = 1'b1;
					req_nxt = !req_r;
					w_kind_nxt = (tx_st_r == TX_SOF) ? IT_SOF :
						(tx_st_r == TX_EOF) ? IT_EOF : IT_DATA;
					w_byte_nxt = (tx_st_r == TX_CRC0) ? ~crc_r[7:0] : ~crc_r[15:8];
				end else if (ack_ev) begin
					pend_nxt = 1'b0;
					tx_st_nxt = (tx_st_r == TX_SOF) ? TX_DATA :
						(tx_st_r == TX_CRC0) ? TX_CRC1 :
						(tx_st_r == TX_CRC1) ? TX_EOF : TX_IDLE;
					tx_done_nxt = tx_st_r == TX_EOF;
				end
			end
			TX_DATA: begin
				if (tx_valid && tx_rdy_r) begin
					pend_nxt = 1'b1;
					req_nxt = !req_r;
					w_kind_nxt = IT_DATA;
					w_byte_nxt = tx_byte;
					last_nxt = tx_last;
					crc_nxt = crc_byte(crc_r, tx_byte);
				end else if (pend_r && ack_ev) begin
					pend_nxt = 1'b0;
					tx_st_nxt = last_r ? TX_CRC0 : TX_DATA;
				end
			end
		endcase
		if (rx_valid) begin
			rx_crc_nxt = rx_c;
			rx_first_nxt = rx_last;
			if (rx_first_r) begin
				q_dual_nxt = rx_byte[`RTF_FLAG_SUB];
				q_low_nxt = !rx_byte[`RTF_FLAG_RATE];
			end
			if (rx_last && rx_c == `RTF_CRC_RESIDUE) begin
				rx_ok_nxt = 1'b1;
				armed_nxt = 1'b1;
				f_dual_nxt = rx_first_r ? rx_byte[`RTF_FLAG_SUB] : q_dual_r;
				f_low_nxt = rx_first_r ? !rx_byte[`RTF_FLAG_RATE] : q_low_r;
			end else if (rx_last) begin
				rx_bad_nxt = 1'b1;
				armed_nxt = 1'b0;
			end
		end
	end

	assign tx_rdy_nxt = (tx_st_nxt == TX_DATA) && !pend_nxt;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_st_r <= TX_IDLE;
			rx_crc_r <= `RTF_CRC_PRESET;
			rx_first_r <= 1'b1;
			rx_ok_r <= 1'b0;
			rx_bad_r <= 1'b0;
			q_dual_r <= 1'b0;
			q_low_r <= 1'b0;
			f_dual_r <= 1'b0;
			f_low_r <= 1'b0;
			armed_r <= 1'b0;
			crc_r <= `RTF_CRC_PRESET;
			pend_r <= 1'b0;
			req_r <= 1'b0;
			last_r <= 1'b0;
			w_kind_r <= IT_SOF;
			w_byte_r <= 8'h00;
			w_dual_r <= 1'b0;
			w_low_r <= 1'b0;
			w_fast_r <= 1'b0;
			tx_rdy_r <= 1'b0;
			tx_busy_r <= 1'b0;
			tx_done_r <= 1'b0;
		end else begin
			tx_st_r <= tx_st_nxt;
			rx_crc_r <= rx_crc_nxt;
			rx_first_r <= rx_first_nxt;
			rx_ok_r <= rx_ok_nxt;
			rx_bad_r <= rx_bad_nxt;
			q_dual_r <= q_dual_nxt;
			q_low_r <= q_low_nxt;
			f_dual_r <= f_dual_nxt;
			f_low_r <= f_low_nxt;
			armed_r <= armed_nxt;
			crc_r <= crc_nxt;
			pend_r <= pend_nxt;
			req_r <= req_nxt;
			last_r <= last_nxt;
			w_kind_r <= w_kind_nxt;
			w_byte_r <= w_byte_nxt;
			w_dual_r <= w_dual_nxt;
			w_low_r <= w_low_nxt;
			w_fast_r <= w_fast_nxt;
			tx_rdy_r <= tx_rdy_nxt;
			tx_busy_r <= tx_st_nxt != TX_IDLE;
			tx_done_r <= tx_done_nxt;
		end
	end

	assign rx_ok = rx_ok_r;
	assign rx_bad = rx_bad_r;
	assign resp_armed = armed_r;
	assign tx_ready = tx_rdy_r;
	assign tx_busy = tx_busy_r;
	assign tx_done = tx_done_r;

	// Checks on the clk side
	chk_talk_first: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(tx_busy_r) |-> $past(armed_r, 2)) else $error("frame began without request");
	chk_bad_drop: assert property (@(posedge clk) disable iff (!rst_b)
		rx_bad_r |-> !armed_r) else $error("bad request left framer armed");
	chk_crc_preset: assert property (@(posedge clk) disable iff (!rst_b)
		tx_st_r == TX_SOF && $past(tx_st_r) == TX_IDLE |-> crc_r == `RTF_CRC_PRESET)
		else $error("response CRC not preset");
	chk_crc_append: assert property (@(posedge clk) disable iff (!rst_b)
		tx_st_r == TX_CRC0 && !pend_r |=> w_byte_r == ~$past(crc_r[7:0]))
		else $error("CRC low byte wrong");
	chk_afi_locked: assert property (@(posedge clk) disable iff (!rst_b)
		afi_lock_r && afi_wr |=> $stable(afi_r) ##0 afi_rej_r)
		else $error("locked family code changed");
	chk_uid_fixed: assert property (@(posedge clk) disable iff (!rst_b)
		1'b1 |=> $stable(uid_r)) else $error("identifier changed");

	// ==================================================================
	// Link side, carrier clock domain
	// ==================================================================
	rtf_lk_e lk_st_r, lk_st_nxt;
	rtf_item_e kind_r, kind_nxt;
	rtf_seg_e typ_r, typ_nxt;
	rtf_seg_s si_cur, si_new;
	rtf_byte_t byte_r, byte_nxt;
	logic lrst_s1_b, lrst_b, req_s1_r, req_s2_r, req_s3_r, req_s3_nxt, lk_ack_nxt;
	logic dual_r, dual_nxt, low_r, low_nxt, fast_r, fast_nxt, lm_r, lm_nxt, load;
	logic [2:0] bit_r, bit_nxt;
	logic [1:0] seg_r, seg_nxt;
	logic [8:0] units_r, units_nxt;
	logic [4:0] phase_r, phase_nxt, last_ph, hi_cnt_r;

	// Reset release and request toggle synchronisers
	always_ff @(posedge fc_clk or negedge rst_b) begin
		if (!rst_b) begin
			lrst_s1_b <= 1'b0;
			lrst_b <= 1'b0;
			req_s1_r <= 1'b0;
			req_s2_r <= 1'b0;
		end else begin
			lrst_s1_b <= 1'b1;
			lrst_b <= lrst_s1_b;
			req_s1_r <= req_r;
			req_s2_r <= req_s1_r;
		end
	end

	// Symbol player: segments of whole subcarrier periods, counted on carrier
	always_comb begin
		lk_st_nxt = lk_st_r;
		kind_nxt = kind_r;
		byte_nxt = byte_r;
		dual_nxt = dual_r;
		low_nxt = low_r;
		fast_nxt = fast_r;
		bit_nxt = bit_r;
		seg_nxt = seg_r;
		units_nxt = units_r;
		phase_nxt = phase_r;
		typ_nxt = typ_r;
		req_s3_nxt = req_s3_r;
		lk_ack_nxt = lk_ack_r;
		load = 1'b0;
		si_cur = seg_info(sym_of(kind_r, byte_r, bit_r), dual_r, seg_r);
		last_ph = (typ_r == SG_HI) ? 5'(`RTF_DIV_HI - 1) : 5'(`RTF_DIV_LO - 1);
		unique case (lk_st_r)
			LK_IDLE: begin
				load = req_s2_r != req_s3_r;
			end
			LK_RUN: begin
				if (phase_r != last_ph) begin
					phase_nxt = phase_r + 5'h1;
				end else if (units_r != 9'h001) begin
					phase_nxt = 5'h0;
					units_nxt = units_r - 9'h001;
				end else if (!si_cur.last) begin
					phase_nxt = 5'h0;
					seg_nxt = seg_r + 2'h1;
				end else if (kind_r == IT_DATA && bit_r != `RTF_LAST_BIT) begin
					phase_nxt = 5'h0;
					bit_nxt = bit_r + 3'h1;
					seg_nxt = 2'h0;
				end else begin
					load = req_s2_r != req_s3_r;
					lk_st_nxt = LK_IDLE;
				end
			end
		endcase
		// Take the next item without a gap, so bytes run back to back
		if (load) begin
			lk_st_nxt = LK_RUN;
			kind_nxt = w_kind_r;
			byte_nxt = w_byte_r;
			dual_nxt = w_dual_r;
			low_nxt = w_low_r;
			fast_nxt = w_fast_r;
			bit_nxt = 3'h0;
			seg_nxt = 2'h0;
			phase_nxt = 5'h0;
			req_s3_nxt = req_s2_r;
			lk_ack_nxt = req_s2_r;
		end
		si_new = seg_info(sym_of(kind_nxt, byte_nxt, bit_nxt), dual_nxt, seg_nxt);
		if (load || seg_nxt != seg_r || bit_nxt != bit_r) begin
			typ_nxt = si_new.typ;
			units_nxt = units_of(si_new.base, low_nxt, fast_nxt);
			// Fast high-rate EOF closes on a longer quiet than half the standard one
			if (kind_nxt == IT_EOF && seg_nxt == 2'h3 && fast_nxt && !low_nxt) begin
				units_nxt = 9'(`RTF_U_FAST_TAIL);
			end
		end
		// Load switched on for the first half of each subcarrier period
		lm_nxt = lk_st_nxt == LK_RUN && typ_nxt != SG_UNMOD &&
			phase_nxt < ((typ_nxt == SG_HI) ? 5'(`RTF_HALF_HI) : 5'(`RTF_HALF_LO));
	end

	always_ff @(posedge fc_clk or negedge lrst_b) begin
		if (!lrst_b) begin
			lk_st_r <= LK_IDLE;
			kind_r <= IT_SOF;
			byte_r <= 8'h00;
			dual_r <= 1'b0;
			low_r <= 1'b0;
			fast_r <= 1'b0;
			bit_r <= 3'h0;
			seg_r <= 2'h0;
			units_r <= 9'h000;
			phase_r <= 5'h0;
			typ_r <= SG_UNMOD;
			req_s3_r <= 1'b0;
			lk_ack_r <= 1'b0;
			lm_r <= 1'b0;
			hi_cnt_r <= 5'h0;
		end else begin
			lk_st_r <= lk_st_nxt;
			kind_r <= kind_nxt;
			byte_r <= byte_nxt;
			dual_r <= dual_nxt;
			low_r <= low_nxt;
			fast_r <= fast_nxt;
			bit_r <= bit_nxt;
			seg_r <= seg_nxt;
			units_r <= units_nxt;
			phase_r <= phase_nxt;
			typ_r <= typ_nxt;
			req_s3_r <= req_s3_nxt;
			lk_ack_r <= lk_ack_nxt;
			lm_r <= lm_nxt;
			hi_cnt_r <= lm_r ? hi_cnt_r + 5'h1 : 5'h0;
		end
	end

	assign load_mod = lm_r;

	// Checks on the link side
	chk_fast_single: assert property (@(posedge fc_clk) disable iff (!lrst_b)
		lk_st_r == LK_RUN && fast_r |-> !dual_r) else $error("fast response on two subcarriers");
	chk_sof_gap: assert property (@(posedge fc_clk) disable iff (!lrst_b)
		$rose(lk_st_r == LK_RUN) && kind_r == IT_SOF && !dual_r |->
		typ_r == SG_UNMOD && units_r == units_of(5'(`RTF_U_LONG), low_r, fast_r))
		else $error("single subcarrier SOF gap wrong");
	chk_sof_dual: assert property (@(posedge fc_clk) disable iff (!lrst_b)
		$rose(lk_st_r == LK_RUN) && kind_r == IT_SOF && dual_r |->
		typ_r == SG_HI && units_r == units_of(5'(`RTF_P_HI_LONG), low_r, 1'b0))
		else $error("two subcarrier SOF start wrong");
	chk_eof_tail: assert property (@(posedge fc_clk) disable iff (!lrst_b)
		lk_st_r == LK_RUN && kind_r == IT_EOF && seg_r == 2'h3 |->
		typ_r == (dual_r ? SG_HI : SG_UNMOD)) else $error("EOF tail wrong");
	chk_eof_quiet: assert property (@(posedge fc_clk) disable iff (!lrst_b)
		lk_st_r == LK_RUN && kind_r == IT_EOF && $changed(seg_r) && seg_r == 2'h3 &&
		fast_r && !low_r |-> units_r == 9'(`RTF_U_FAST_TAIL))
		else $error("fast EOF closing quiet wrong");
	chk_pulse_half: assert property (@(posedge fc_clk) disable iff (!lrst_b)
		$fell(lm_r) |-> $past(hi_cnt_r) == 5'(`RTF_HALF_LO - 1) ||
		$past(hi_cnt_r) == 5'(`RTF_HALF_HI - 1)) else $error("subcarrier half period wrong");
	chk_bit_order: assert property (@(posedge fc_clk) disable iff (!lrst_b)
		$changed(req_s3_r) && kind_r == IT_DATA |-> bit_r == 3'h0 &&
		typ_r == (byte_r[0] ? (dual_r ? SG_HI : SG_UNMOD) : SG_LO))
		else $error("byte not sent LSB first");

endmodule : rtf_framer

// File: rtf_reader_model.sv
// Reader model: carrier source, pulse counter and fast one-subcarrier bit decoder
`timescale 1ns/10ps
module rtf_reader_model (
	output logic fc_clk = 1'b0,
	input wire logic load_mod,
	output int edges = 0,
	output int nb = 0,
	output logic [23:0] rxw = 24'h000000
);
	int tick = 0;
	int t0 = -1;
	logic prev = 1'b0;
	// ==================================================================
	// Carrier
	// ==================================================================
	// Field is on for the whole run, so the carrier runs free
	always #24 fc_clk = ~fc_clk;
	// ==================================================================
	// Receiver
	// ==================================================================
	// Count every subcarrier pulse; sample each bit slot after the start
	// delimiter, where a one has pulses in its second half
	always @(posedge fc_clk) begin
		tick <= tick + 1;
		prev <= load_mod;
		if (load_mod && !prev) begin
			edges <= edges + 1;
			if (t0 < 0) t0 <= tick;
		end
		if (t0 >= 0 && nb < 24 && tick - t0 >= 640 && (tick - t0 - 640) % 256 == 132) begin
			rxw <= {load_mod, rxw[23:1]};
			nb <= nb + 1;
		end
	end
endmodule : rtf_reader_model

// File: tb_top.sv
// Testbench for the tag response framer
`timescale 1ns/10ps
module tb_top;
	import rtf_pkg::*;
	logic clk = 1'b0;
	logic rst_b;
	logic rx_valid = 1'b0;
	logic rx_last = 1'b0;
	logic tx_start = 1'b0;
	logic tx_fast = 1'b0;
	logic tx_valid = 1'b0;
	logic tx_last = 1'b0;
	logic afi_wr = 1'b0;
	logic afi_lock_wr = 1'b0;
	rtf_byte_t rx_byte = 8'h00;
	rtf_byte_t tx_byte = 8'h00;
	rtf_byte_t afi_wdata = 8'h00;
	rtf_byte_t d;
	logic fc_clk, rx_ok, rx_bad, resp_armed, tx_ready, tx_busy, tx_done;
	logic afi_locked, afi_reject, load_mod;
	logic [3:0] afi_family, afi_subfamily;
	logic [63:0] uid;
	logic [23:0] rxw;
	logic [15:0] k;
	int edges, nb, i;
	int fails = 0;
	int cmp_count = 0;
	logic [1:0] exp_rx[$];
	logic [23:0] exp_link[$];

	// Identifier values are arbitrary
	rtf_framer #(
		.UID_CLASS(8'h3c),
		.UID_MAKER(8'hc3),
		.UID_SERIAL(48'h1122_3344_5566)
	) u_rtf_framer (
		.clk(clk),
		.rst_b(rst_b),
		.fc_clk(fc_clk),
		.rx_valid(rx_valid),
		.rx_byte(rx_byte),
		.rx_last(rx_last),
		.rx_ok(rx_ok),
		.rx_bad(rx_bad),
		.resp_armed(resp_armed),
		.tx_start(tx_start),
		.tx_fast(tx_fast),
		.tx_valid(tx_valid),
		.tx_byte(tx_byte),
		.tx_last(tx_last),
		.tx_ready(tx_ready),
		.tx_busy(tx_busy),
		.tx_done(tx_done),
		.afi_wr(afi_wr),
		.afi_wdata(afi_wdata),
		.afi_lock_wr(afi_lock_wr),
		.afi_family(afi_family),
		.afi_subfamily(afi_subfamily),
		.afi_locked(afi_locked),
		.afi_reject(afi_reject),
		.uid(uid),
		.load_mod(load_mod)
	);
	rtf_reader_model u_rtf_reader_model (
		.fc_clk(fc_clk),
		.load_mod(load_mod),
		.edges(edges),
		.nb(nb),
		.rxw(rxw)
	);

	always #2.5 clk = ~clk;

	// ==================================================================
	// Helpers
	// ==================================================================
	function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
		c = c ^ {8'h00, b};
		for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
		return c;
	endfunction : crc_upd

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish;
		$display("Comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	task automatic lim(input int n);
		if (i >= n) begin
			fails++;
			tally_and_finish();
		end
	endtask : lim

	task automatic put(input logic [7:0] b, input logic l);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_byte <= b;
		rx_last <= l;
	endtask : put

	// Request: flags, command, check value low byte first
	task automatic send_req(input logic [7:0] f, input logic [7:0] c, input logic bad);
		logic [15:0] v;
		v = ~crc_upd(crc_upd(16'hffff, f), c);
		if (bad) v = v ^ 16'h0001;
		exp_rx.push_back(bad ? 2'b01 : 2'b10);
		put(f, 1'b0);
		put(c, 1'b0);
		put(v[7:0], 1'b0);
		put(v[15:8], 1'b1);
		@(posedge clk) rx_valid <= 1'b0;
	endtask : send_req

	// ==================================================================
	// Monitor
	// ==================================================================
	// Take the oldest note whenever the design or the reader shows a result
	always @(posedge clk) begin
		if (rx_ok !== 1'b0 || rx_bad !== 1'b0) begin
			if (exp_rx.size() == 0) check({rx_ok, rx_bad}, 2'b00);
			else check({rx_ok, rx_bad}, exp_rx.pop_front());
		end
		if (nb == 24 && exp_link.size() > 0) check(rxw, exp_link.pop_front());
	end

	// ==================================================================
	// Sequence
	// ==================================================================
	initial begin
		void'($urandom(32'he1e0ffaf));
		// Assert reset by an event so every async-reset flop sees it
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (10) @(posedge clk);
		check(uid, {8'h3c, 8'hc3, 48'h1122_3344_5566});
		d = 8'($urandom);
		afi_wr <= 1'b1;
		afi_wdata <= d;
		@(posedge clk) afi_wr <= 1'b0;
		afi_lock_wr <= 1'b1;
		@(posedge clk) afi_lock_wr <= 1'b0;
		afi_wr <= 1'b1;
		afi_wdata <= ~d;
		@(posedge clk) afi_wr <= 1'b0;
		@(posedge clk);
		check({afi_family, afi_subfamily, afi_locked, afi_reject}, {d, 2'b11});
		$display("family code test done");
		// Bad request is dropped and a start attempt stays silent
		send_req(8'h03, 8'($urandom), 1'b1);
		tx_start <= 1'b1;
		@(posedge clk) tx_start <= 1'b0;
		repeat (40) @(posedge clk);
		check({resp_armed, tx_busy, load_mod, edges[7:0]}, 64'h0);
		$display("bad request test done");
		// Good request asking two subcarriers, high rate; fast response
		send_req(8'h03, 8'($urandom), 1'b0);
		@(posedge clk);
		check(resp_armed, 1'b1);
		d = 8'($urandom);
		k = ~crc_upd(16'hffff, d);
		exp_link.push_back({k, d});
		tx_start <= 1'b1;
		tx_fast <= 1'b1;
		tx_valid <= 1'b1;
		tx_byte <= d;
		tx_last <= 1'b1;
		@(posedge clk) tx_start <= 1'b0;
		for (i = 0; i < 20000 && tx_ready !== 1'b1; i++) @(posedge clk);
		lim(20000);
		tx_valid <= 1'b0;
		for (i = 0; i < 90000 && tx_done !== 1'b1; i++) @(posedge clk);
		lim(90000);
		repeat (14000) @(posedge clk);
		check({edges, tx_busy, load_mod}, {32'd128, 2'b00});
		check(exp_link.size(), 0);
		$display("fast response test done");
		tally_and_finish();
	end
endmodule : tb_top
